/* File: core/cfs_supervisor.v */
// channel fault supervisor: comm watchdog, fault codes, overcurrent shutdown.
// assumes apb on clock, shutoff pins and hard clear from pins, sense flags synchronous.
`timescale 1ns/1ps
`include "cfs_defines.vh"

// Functional notes
// R01: watchdog starts once both shutoff pins release
// R02: pins released after clear: normal window
// R03: pins released before clear: long first window
// R04: after valid frame always normal window
// R05: expiry disables channels 1-6, sets flag
// R06: valid frame restarts timer, re-enables outputs
// R07: watchdog on at reset, disable bit, status
// R08: h-bridge channels 7,8 also disabled
// R09: diagnostics off reports no-diagnostic code
// R10: diag request frame then read codes
// R11: fixed 3-bit code encoding and priority
// R12: only highest priority event encoded
// R13: code 000 only in peak-and-hold
// R14: msb zero exactly on failure
// R15: latches clear on readout or reset
// R16: event during readout kept for next
// R17: on reports 101, once 100 after turn-on
// R18: overcurrent shuts output, reports 001
// R19: boost gate current table on overcurrent
// R20: boost immediate, restored after diag read
// R21: re-arm by toggle or readout plus toggle
// R22: h-bridge always needs readout; source select
module cfs_supervisor
#(
   parameter NCH = 8,
   parameter [31:0] T_CC_CYC = `CFS_T_CC_CYC,
   parameter [31:0] T_CC_INIT_CYC = `CFS_T_CC_INIT_CYC
)
(
   input wire clock,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire shutoff_pin_low,
   input wire shutoff_pin_high,
   input wire hard_clear_n,
   input wire [NCH-1:0] channel_input_pin_n,
   input wire [NCH-1:0] oc_event,
   input wire [NCH-1:0] oc_in_blank,
   input wire [NCH-1:0] short_event,
   input wire [NCH-1:0] open_load_event,
   input wire [NCH-1:0] off_ok_event,
   output reg [NCH-1:0] channel_on_q,
   output reg [2*NCH-1:0] gate_drive_sel_q,
   output reg comm_timeout_flag_q
);

   // ***************************************
   // pin synchronisers
   // ***************************************
   reg [2:0] pin_s1_q; // first stage, read by second only
   reg [2:0] pin_s2_q;
   reg [NCH-1:0] in_s1_q;
   reg [NCH-1:0] in_s2_q;
   always @(posedge clock)
   begin
      pin_s1_q <= {hard_clear_n, shutoff_pin_high, shutoff_pin_low};
      pin_s2_q <= pin_s1_q;
      in_s1_q <= channel_input_pin_n;
      in_s2_q <= in_s1_q;
   end
   // released: low pin high, high pin low
   wire pins_free = pin_s2_q[0] & ~pin_s2_q[1];
   wire clr_n = pin_s2_q[2];
   wire any_reset = ~rst_n | ~clr_n;

   // ***************************************
   // registers
   // ***************************************
   reg [31:0] ctrl_q;      // watchdog disable, check on, boost, hbridge
   reg [NCH-1:0] src_sel_q; // 1: serial_channel_on drives channel
   reg [NCH-1:0] ph_mode_q; // peak-and-hold channels
   reg [NCH-1:0] rearm_q;   // 1: readout needed before toggle
   reg [NCH-1:0] son_q;     // serial_channel_on
   reg [2*NCH-1:0] gsel_q;  // gate_current_sel per channel
   reg [3*NCH-1:0] fc_q;    // latched fault_code per channel
   reg [3*NCH-1:0] snap_q;  // report captured by diag request
   reg [NCH-1:0] oc_lat_q;  // channel off after overcurrent
   reg [NCH-1:0] rd_ok_q;   // readout seen since overcurrent
   reg [NCH-1:0] ctl_prev_q;
   reg [NCH-1:0] was_on_q;
   reg [NCH-1:0] boost_q;   // boosted shutdown current active

   wire wr_en = psel & penable & pwrite & pready;
   wire rd_en = psel & penable & ~pwrite & pready;
   wire diag_req = wr_en && paddr == `CFS_REG_DIAG_REQ && pwdata == `CFS_DIAG_KEY; // see R10
   wire diag_read = rd_en && paddr == `CFS_REG_DIAG;
   wire wdg_en = ~ctrl_q[`CFS_CTRL_WDG_DIS];
   wire hbr = ctrl_q[`CFS_CTRL_HBRIDGE];
   wire fchk = ctrl_q[`CFS_CTRL_FCHK_ON];
   // any valid mapped write counts as a good frame
   wire valid_frame = wr_en & addr_ok(paddr);

   // mapped address decode, shared by write and read
   function addr_ok;
      input [11:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (a <= `CFS_REG_OUT);
      end
   endfunction

   // boosted shutdown current from configured one
   function [1:0] boost_of;
      input [1:0] g;
      input sel;
      begin
         if (g == `CFS_GC_1MA)
            boost_of = sel ? `CFS_GC_20MA : `CFS_GC_5MA; // see R19
         else if (g == `CFS_GC_5MA)
            boost_of = `CFS_GC_20MA; // see R19
         else
            boost_of = g;
      end
   endfunction

   // ***************************************
   // apb slave, zero wait state
   // ***************************************
   always @(posedge clock)
   begin
      if (!rst_n)
      begin
         ctrl_q <= `CFS_CTRL_RESET; // see R07
         src_sel_q <= {NCH{1'b0}};
         ph_mode_q <= {NCH{1'b0}};
         rearm_q <= {NCH{1'b0}};
         son_q <= {NCH{1'b0}};
         gsel_q <= {2*NCH{1'b0}};
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         // ready asserted in the access phase only
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok(paddr);
         // refused writes also load zero, so a refusal never shows stale data
         if (psel & ~penable & (~pwrite | ~addr_ok(paddr)))
         begin
            case (paddr)
               `CFS_REG_CTRL: prdata <= ctrl_q;
               `CFS_REG_STATUS: prdata <= {30'h0, wdg_en, comm_timeout_flag_q}; // see R07
               `CFS_REG_DIAG: prdata <= {{(32-3*NCH){1'b0}}, snap_q}; // see R10
               `CFS_REG_CHCFG: prdata <= {8'h00, rearm_q, ph_mode_q, src_sel_q};
               `CFS_REG_CHON: prdata <= {24'h0, son_q};
               `CFS_REG_GATE: prdata <= {16'h0, gsel_q};
               `CFS_REG_OUT: prdata <= {24'h0, channel_on_q};
               default: prdata <= 32'h0000_0000;
            endcase
         end
         if (wr_en)
         begin
            case (paddr)
               `CFS_REG_CTRL: ctrl_q <= {28'h0, pwdata[3:0]}; // see R07
               `CFS_REG_CHCFG:
               begin
                  src_sel_q <= pwdata[NCH-1:0];
                  ph_mode_q <= pwdata[2*NCH-1:NCH];
                  rearm_q <= pwdata[3*NCH-1:2*NCH];
               end
               `CFS_REG_CHON: son_q <= pwdata[NCH-1:0];
               `CFS_REG_GATE: gsel_q <= pwdata[2*NCH-1:0];
               default: ctrl_q <= ctrl_q;
            endcase
         end
      end
   end

   // ***************************************
   // comm watchdog
   // ***************************************
   // windows use the minimum figures, so the host always gets at least the
   // promised deadline; the trade is a slightly earlier shutoff
   reg [31:0] wdg_cnt_q;   // cycles left in current window
   reg wdg_run_q;          // timer started
   reg early_free_q;       // pins were free while clear held
   reg clr_prev_q;
   reg wdg_exp_q;          // outputs disabled by expiry
   always @(posedge clock)
   begin
      if (any_reset)
      begin
         wdg_run_q <= 1'b0;
         wdg_cnt_q <= 32'h0000_0000;
         wdg_exp_q <= 1'b0;
         clr_prev_q <= 1'b0;
         early_free_q <= 1'b0;
         // pins free during clear: long window follows
         if (rst_n & ~clr_n)
            early_free_q <= pins_free; // see R03
      end
      else
      begin
         clr_prev_q <= 1'b1;
         if (!wdg_en || !pins_free)
         begin
            // held off until both pins release
            wdg_run_q <= 1'b0; // see R01
            wdg_exp_q <= 1'b0;
            early_free_q <= early_free_q & ~clr_prev_q;
         end
         else if (!wdg_run_q)
         begin
            wdg_run_q <= 1'b1; // see R01
            // long window only when pins preceded clear release
            wdg_cnt_q <= early_free_q ? T_CC_INIT_CYC : T_CC_CYC; // see R02 R03
            early_free_q <= 1'b0;
         end
         else if (valid_frame)
         begin
            wdg_cnt_q <= T_CC_CYC; // see R04 R06
            wdg_exp_q <= 1'b0; // see R06
         end
         else if (wdg_cnt_q > 32'h0000_0001)
            wdg_cnt_q <= wdg_cnt_q - 32'h0000_0001;
         else
            wdg_exp_q <= 1'b1; // see R05
      end
   end

   // timeout flag: set wins over read clear
   wire st_read = rd_en && paddr == `CFS_REG_STATUS;
   // set once on entry into expiry, so a read while still expired clears it;
   // a hard clear drops it along with the rest of the watchdog
   always @(posedge clock)
   begin
      if (any_reset)
         comm_timeout_flag_q <= 1'b0;
      else if (wdg_run_q && wdg_en && pins_free && !valid_frame && !wdg_exp_q && wdg_cnt_q <= 32'h0000_0001)
         comm_timeout_flag_q <= 1'b1; // see R05
      else if (st_read)
         comm_timeout_flag_q <= 1'b0; // see R05
   end

   // ***************************************
   // per-channel fault and output logic
   // ***************************************
   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1)
      begin : g_ch
         // control signal from pin or serial bit
         wire ctl = src_sel_q[i] ? son_q[i] : ~in_s2_q[i]; // see R22
         wire toggle = ctl & ~ctl_prev_q[i];
         // channels 7,8 exempt unless h-bridge
         wire wdg_off = wdg_exp_q & ((i < 6) | hbr); // see R05 R08
         wire need_rd = hbr | rearm_q[i]; // see R21 R22
         wire rearm = toggle & (~need_rd | rd_ok_q[i]); // see R21
         wire [2:0] cur = fc_q[3*i+2:3*i];
         reg [2:0] nxt;
         // priority encode new event against latched code
         always @*
         begin
            nxt = cur;
            if (!fchk)
               nxt = `CFS_FC_NODIAG; // see R09
            else if (oc_event[i] & channel_on_q[i] && cur != `CFS_FC_OCPIN)
               // pin failure only in peak-and-hold; a latched pin failure outranks it
               nxt = (ph_mode_q[i] & oc_in_blank[i]) ? `CFS_FC_OCPIN : `CFS_FC_OC; // see R13 R18
            else if (short_event[i] && cur > `CFS_FC_SHORT)
               nxt = `CFS_FC_SHORT; // see R12
            else if (open_load_event[i] && cur > `CFS_FC_OL)
               nxt = `CFS_FC_OL; // see R12
            else if (channel_on_q[i] & ~was_on_q[i] && cur == `CFS_FC_NOOFF)
               nxt = `CFS_FC_NOFAIL; // see R17
            else if (channel_on_q[i] && cur > `CFS_FC_NOOC)
               nxt = `CFS_FC_NOOC; // see R17
            else if (off_ok_event[i] && cur == `CFS_FC_NODIAG)
               nxt = `CFS_FC_NOOFF; // see R11
            // oc pin code never kept outside peak-and-hold
            if (nxt == `CFS_FC_OCPIN && !ph_mode_q[i])
               nxt = `CFS_FC_OC; // see R13
         end
         always @(posedge clock)
         begin
            if (any_reset)
            begin
               // filters and latches cleared on any reset
               fc_q[3*i+2:3*i] <= `CFS_FC_NODIAG; // see R15
               snap_q[3*i+2:3*i] <= `CFS_FC_NODIAG;
               oc_lat_q[i] <= 1'b0;
               rd_ok_q[i] <= 1'b0;
               ctl_prev_q[i] <= 1'b0;
               was_on_q[i] <= 1'b0;
               boost_q[i] <= 1'b0;
               channel_on_q[i] <= 1'b0;
               gate_drive_sel_q[2*i+1:2*i] <= `CFS_GC_1MA;
            end
            else
            begin
               ctl_prev_q[i] <= ctl;
               was_on_q[i] <= channel_on_q[i];
               if (diag_req)
               begin
                  snap_q[3*i+2:3*i] <= nxt; // see R10
                  fc_q[3*i+2:3*i] <= fchk ? `CFS_FC_NODIAG : nxt; // see R15
               end
               else if (diag_read & ~(oc_event[i] | short_event[i] | open_load_event[i]))
                  fc_q[3*i+2:3*i] <= nxt;
               else
                  // events during readout land here and wait
                  fc_q[3*i+2:3*i] <= nxt; // see R16
               // overcurrent: latch off and boost at once
               if (oc_event[i] & channel_on_q[i])
               begin
                  oc_lat_q[i] <= 1'b1; // see R18
                  boost_q[i] <= 1'b1; // see R20
                  rd_ok_q[i] <= 1'b0;
               end
               else
               begin
                  if (diag_read)
                  begin
                     rd_ok_q[i] <= oc_lat_q[i];
                     boost_q[i] <= 1'b0; // see R20
                  end
                  if (rearm)
                     oc_lat_q[i] <= 1'b0; // see R21
               end
               channel_on_q[i] <= ctl & ~oc_lat_q[i] & ~(oc_event[i] & channel_on_q[i]) & ~wdg_off; // see R05 R18
               gate_drive_sel_q[2*i+1:2*i] <= (boost_q[i] | (oc_event[i] & channel_on_q[i]))
                  ? boost_of(gsel_q[2*i+1:2*i], ctrl_q[`CFS_CTRL_BOOST_SEL]) : gsel_q[2*i+1:2*i]; // see R19 R20
            end
         end
      end
   endgenerate

   // msb of each code is clear exactly for failures  see R14
endmodule

/* File: core/cfs_defines.vh */
// constants for the channel fault supervisor: register map, fields, codes, timing.
// assumes a 32-bit apb slave on a 100 MHz clock.
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH
// ***************************************
// register byte offsets
// ***************************************
`define CFS_REG_CTRL 12'h000
`define CFS_REG_STATUS 12'h004
`define CFS_REG_DIAG_REQ 12'h008
`define CFS_REG_DIAG 12'h00C
`define CFS_REG_CHCFG 12'h010
`define CFS_REG_CHON 12'h014
`define CFS_REG_GATE 12'h018
`define CFS_REG_OUT 12'h01C
// ***************************************
// ctrl fields
// ***************************************
`define CFS_CTRL_WDG_DIS 0
`define CFS_CTRL_FCHK_ON 1
`define CFS_CTRL_BOOST_SEL 2
`define CFS_CTRL_HBRIDGE 3
`define CFS_CTRL_RESET 32'h0000_0002
// ***************************************
// diagnostic request key and codes
// ***************************************
`define CFS_DIAG_KEY 32'h9AAA_0001
`define CFS_FC_OCPIN 3'h0
`define CFS_FC_OC 3'h1
`define CFS_FC_SHORT 3'h2
`define CFS_FC_OL 3'h3
`define CFS_FC_NOFAIL 3'h4
`define CFS_FC_NOOC 3'h5
`define CFS_FC_NOOFF 3'h6
`define CFS_FC_NODIAG 3'h7
// gate current codes
`define CFS_GC_1MA 2'h0
`define CFS_GC_5MA 2'h1
`define CFS_GC_20MA 2'h2
// ***************************************
// timing, ms and cycles at 100 MHz
// ***************************************
`define CFS_CLK_KHZ 100000
`define CFS_T_CC_MS 55
`define CFS_T_CC_INIT_MS 110
`define CFS_T_CC_CYC (`CFS_T_CC_MS * `CFS_CLK_KHZ)
`define CFS_T_CC_INIT_CYC (`CFS_T_CC_INIT_MS * `CFS_CLK_KHZ)
`endif

/* File: verif/cfs_host_pins.sv */
// host pin model: both shutoff pins and the hard clear pin.
// assumes the bench commands it just after a rising edge.
`timescale 1ns/1ps
module cfs_host_pins
(
   input wire clock,
   input wire release_pins,
   input wire clear_on,
   output reg shutoff_pin_low,
   output reg shutoff_pin_high,
   output reg hard_clear_n
);
   // power-up: shutoff pins not released, watchdog held off, clear asserted
   initial
   begin
      shutoff_pin_low = 1'b0;
      shutoff_pin_high = 1'b1;
      hard_clear_n = 1'b0;
   end
   // pins move together; their order against clear picks the first window
   always @(posedge clock)
   begin
      shutoff_pin_low <= release_pins;
      shutoff_pin_high <= !release_pins;
      hard_clear_n <= !clear_on;
   end
endmodule

/* File: verif/cfs_supervisor_chk.sv */
// checker for the channel fault supervisor, bound onto its ports.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "cfs_defines.vh"
module cfs_supervisor_chk
#(
   parameter NCH = 8,
   parameter [31:0] T_CC_CYC = 32'h32,
   parameter [31:0] T_CC_INIT_CYC = 32'h64
)
(
   input wire clock,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire shutoff_pin_low,
   input wire hard_clear_n,
   input wire [NCH-1:0] oc_event,
   input wire [NCH-1:0] channel_on_q,
   input wire [2*NCH-1:0] gate_drive_sel_q,
   input wire comm_timeout_flag_q
);
   // ****************
   // helper logic
   // ****************
   reg [3:0] hc_q; // clear pin history, spans the pin synchroniser
   wire hc_ok = hard_clear_n && (hc_q == 4'hF); // no clear in flight
   wire st_rd = psel && penable && !pwrite && (paddr == `CFS_REG_STATUS); // status read
   // shift the clear pin history
   always @(posedge clock)
   begin
      hc_q <= {hc_q[2:0], hard_clear_n};
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_apb_ans; psel && !penable |=> pready; endproperty
   property p_rdy_one; pready |=> !pready; endproperty
   property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
   property p_flag_hold; comm_timeout_flag_q && hc_ok && !st_rd |=> comm_timeout_flag_q; endproperty
   property p_held; !shutoff_pin_low [*5] |-> !$rose(comm_timeout_flag_q); endproperty
   property p_wdg_off; $rose(comm_timeout_flag_q) |-> ##[0:2] channel_on_q[5:0] == 6'h00; endproperty
   property p_oc_off; oc_event[0] |-> ##[1:3] !channel_on_q[0]; endproperty
   property p_boost;
      oc_event[0] && channel_on_q[0] && gate_drive_sel_q[1:0] == 2'h0 |-> ##[1:2] gate_drive_sel_q[1:0] != 2'h0;
   endproperty
   property p_clear; !hard_clear_n [*3] |-> ##[0:3] channel_on_q == '0 && !comm_timeout_flag_q; endproperty
   a_apb_ans: assert property (p_apb_ans) else $error("no answer after setup");
   a_rdy_one: assert property (p_rdy_one) else $error("ready longer than one cycle");
   a_err_zero: assert property (p_err_zero) else $error("refused read gave data");
   a_flag_hold: assert property (p_flag_hold) else $error("timeout flag lost unread");
   a_held: assert property (p_held) else $error("watchdog ran with pins held");
   a_wdg_off: assert property (p_wdg_off) else $error("channels left on after timeout");
   a_oc_off: assert property (p_oc_off) else $error("overcurrent did not shut off");
   a_boost: assert property (p_boost) else $error("shutdown current not boosted");
   a_clear: assert property (p_clear) else $error("hard clear left state set");
   c_timeout: cover property ($rose(comm_timeout_flag_q));
   c_refused: cover property (pready && pslverr);
   c_oc: cover property (oc_event[0] && channel_on_q[0]);
endmodule
bind cfs_supervisor cfs_supervisor_chk #(.NCH(NCH), .T_CC_CYC(T_CC_CYC), .T_CC_INIT_CYC(T_CC_INIT_CYC)) u_chk (
   .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .shutoff_pin_low,
   .hard_clear_n, .oc_event, .channel_on_q, .gate_drive_sel_q, .comm_timeout_flag_q);

/* File: verif/test_cfs_supervisor.sv */
// bench for the channel fault supervisor: apb master tasks and scenarios.
// assumes the host pin model and a short watchdog window of 50/100 cycles.
`timescale 1ns/1ps
`include "cfs_defines.vh"
module test_cfs_supervisor;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, release_pins = 1'b0, clear_on = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, flag, pin_lo, pin_hi, hc_n;
   logic [7:0] pin_n = 8'hFF, oc = 8'h00, blank = 8'h00, shrt = 8'h00, ol = 8'h00, offok = 8'h00, on;
   logic [15:0] gate;
   logic [1:0] b;
   integer error_cnt = 0, n_checks = 0;
   // short windows keep the run small; expectations follow from 50 and 100
   cfs_supervisor #(.NCH(8), .T_CC_CYC(32'h32), .T_CC_INIT_CYC(32'h64)) u_dut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .shutoff_pin_low(pin_lo),
      .shutoff_pin_high(pin_hi), .hard_clear_n(hc_n), .channel_input_pin_n(pin_n), .oc_event(oc),
      .oc_in_blank(blank), .short_event(shrt), .open_load_event(ol), .off_ok_event(offok),
      .channel_on_q(on), .gate_drive_sel_q(gate), .comm_timeout_flag_q(flag));
   cfs_host_pins u_host (.clock(clock), .release_pins(release_pins), .clear_on(clear_on),
      .shutoff_pin_low(pin_lo), .shutoff_pin_high(pin_hi), .hard_clear_n(hc_n));
   // ****************
   // clock and tasks
   // ****************
   initial
   begin
      forever #5 clock = ~clock;
   end
   task cyc(input integer k);
      repeat (k) @(posedge clock);
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks = n_checks + 1;
      if (got !== ex)
      begin
         error_cnt = error_cnt + 1;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one apb transfer; waits for pready, then one idle edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         // no cycle count assumed: only the hang guard ends this wait
         while (pready !== 1'b1)
            @(posedge clock);
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clock);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************
   // scenarios
   // ****************
   task t_regs;
      apb(1'b0, `CFS_REG_CTRL, 32'h0);
      chk("ctrl", `CFS_CTRL_RESET, r);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", 32'h1, 32'(e));
      chk("rdata", 32'h0, r);
      $display("test regs done");
   endtask
   task t_short;
      release_pins <= 1'b1;
      cyc(40);
      chk("flag", 32'h0, 32'(flag));
      cyc(30);
      chk("flag", 32'h1, 32'(flag));
      apb(1'b1, `CFS_REG_CHCFG, 32'hFF);
      apb(1'b1, `CFS_REG_CHON, 32'hFF);
      cyc(2);
      chk("on", 32'hFF, 32'(on));
      apb(1'b0, `CFS_REG_STATUS, 32'h0);
      chk("status", 32'h3, r);
      cyc(70);
      chk("on", 32'hC0, 32'(on));
      apb(1'b1, `CFS_REG_CHON, 32'hFF);
      cyc(2);
      chk("on", 32'hFF, 32'(on));
      apb(1'b0, `CFS_REG_STATUS, 32'h0);
      chk("status", 32'h3, r);
      apb(1'b0, `CFS_REG_STATUS, 32'h0);
      chk("status", 32'h2, r);
      $display("test short window done");
   endtask
   task t_long;
      clear_on <= 1'b1;
      cyc(5);
      clear_on <= 1'b0;
      cyc(80);
      chk("flag", 32'h0, 32'(flag));
      cyc(50);
      chk("flag", 32'h1, 32'(flag));
      apb(1'b0, `CFS_REG_STATUS, 32'h0);
      chk("status", 32'h3, r);
      // a read is no frame: this write restarts on the normal window
      apb(1'b1, `CFS_REG_CHON, 32'hFF);
      cyc(40);
      chk("flag", 32'h0, 32'(flag));
      cyc(30);
      chk("flag", 32'h1, 32'(flag));
      $display("test long window done");
   endtask
   task t_oc;
      for (b = 2'h0; b < 2'h2; b = b + 2'h1)
      begin
         apb(1'b1, `CFS_REG_CTRL, {29'h0, b[0], 2'h3});
         apb(1'b1, `CFS_REG_CHCFG, 32'hFF);
         apb(1'b1, `CFS_REG_GATE, 32'h0);
         apb(1'b1, `CFS_REG_CHON, 32'h1);
         oc[0] <= 1'b1;
         cyc(4);
         oc[0] <= 1'b0;
         chk("on0", 32'h0, 32'(on[0]));
         chk("gate0", b[0] ? 32'h2 : 32'h1, 32'(gate[1:0]));
         apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
         apb(1'b0, `CFS_REG_DIAG, 32'h0);
         chk("code0", 32'h1, 32'(r[2:0]));
         cyc(2);
         chk("gate0", 32'h0, 32'(gate[1:0]));
         apb(1'b1, `CFS_REG_CHON, 32'h1);
         chk("on0", 32'h0, 32'(on[0]));
         apb(1'b1, `CFS_REG_CHON, 32'h0);
         apb(1'b1, `CFS_REG_CHON, 32'h1);
         cyc(2);
         chk("on0", 32'h1, 32'(on[0]));
      end
      $display("test overcurrent done");
   endtask
   task t_prio;
      apb(1'b1, `CFS_REG_CTRL, 32'h3);
      shrt[1] <= 1'b1;
      ol[1] <= 1'b1;
      ol[3] <= 1'b1;
      cyc(8);
      shrt <= 8'h00;
      ol <= 8'h00;
      apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
      // open load on channel 4 while the report is being read
      ol[4] <= 1'b1;
      apb(1'b0, `CFS_REG_DIAG, 32'h0);
      ol[4] <= 1'b0;
      chk("code1", 32'h2, 32'(r[5:3]));
      chk("msb1", 32'h0, 32'(r[5]));
      chk("code3", 32'h3, 32'(r[11:9]));
      apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
      apb(1'b0, `CFS_REG_DIAG, 32'h0);
      chk("msb1", 32'h1, 32'(r[5]));
      chk("code4", 32'h3, 32'(r[14:12]));
      apb(1'b1, `CFS_REG_CTRL, 32'h1);
      apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
      apb(1'b0, `CFS_REG_DIAG, 32'h0);
      chk("codes", 32'hFFFFFF, {8'h00, r[23:0]});
      $display("test priority done");
   endtask
   task t_rearm;
      apb(1'b1, `CFS_REG_CTRL, 32'h3);
      // channel 0: serial control, peak-and-hold, readout before re-arm
      apb(1'b1, `CFS_REG_CHCFG, 32'h0101FF);
      blank[0] <= 1'b1;
      oc[0] <= 1'b1;
      cyc(2);
      oc[0] <= 1'b0;
      blank[0] <= 1'b0;
      apb(1'b1, `CFS_REG_CHON, 32'h0);
      apb(1'b1, `CFS_REG_CHON, 32'h1);
      cyc(2);
      chk("on0", 32'h0, 32'(on[0]));
      apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
      apb(1'b0, `CFS_REG_DIAG, 32'h0);
      chk("code0", 32'h0, 32'(r[2:0]));
      // off-state pass while off, then turn-on: one no-failure report
      offok[0] <= 1'b1;
      cyc(2);
      offok[0] <= 1'b0;
      apb(1'b1, `CFS_REG_CHON, 32'h0);
      apb(1'b1, `CFS_REG_CHON, 32'h1);
      cyc(2);
      chk("on0", 32'h1, 32'(on[0]));
      apb(1'b1, `CFS_REG_DIAG_REQ, `CFS_DIAG_KEY);
      apb(1'b0, `CFS_REG_DIAG, 32'h0);
      chk("code0", 32'h4, 32'(r[2:0]));
      $display("test re-arm done");
   endtask
   task t_hbridge;
      apb(1'b1, `CFS_REG_CHON, 32'hC1);
      // watchdog on with the bridge bit: a lapse takes the last pair too
      apb(1'b1, `CFS_REG_CTRL, 32'hA);
      cyc(2);
      chk("on", 32'hC1, 32'(on));
      cyc(58);
      chk("on", 32'h0, 32'(on));
      apb(1'b1, `CFS_REG_CTRL, 32'h3);
      $display("test bridge done");
   endtask
   // main sequence: reset, then every scenario in turn
   initial
   begin
      cyc(10);
      rst_n <= 1'b1;
      clear_on <= 1'b0;
      cyc(5);
      t_regs;
      t_short;
      t_long;
      t_oc;
      t_prio;
      t_rearm;
      t_hbridge;
      give_verdict;
   end
   // hang guard: the scenarios need well under 2000 cycles
   initial
   begin
      cyc(20000);
      error_cnt = error_cnt + 1;
      give_verdict;
   end
endmodule
